//--- sjsr_top.sv
// Purpose: scan registers of the memory behind the four-wire test port
// Assumes: test clock far slower than core clock, pins not synchronous
// Notes: io ring value is core-clock logic and is read without sync
// Notes: test clock must stay at least three core cycles high and low,
//    or its edges are lost in the synchroniser
// Notes: every register acts on the state held before the tck rise
// Notes: tdo is driven only in the two shift states
// Notes: unknown opcodes fall back to the bypass stage
//
// Behaviour
// - The 3-bit instruction loads the id code at power-up and in reset.
// - A new instruction shifts in only while the IR path is selected.
// - The loaded instruction acts from run-test/idle or the DR states.
// - A one-bit bypass stage passes scan data with minimal delay.
// - Under the id instruction the 32-bit id word loads in capture-DR.
// - After capture the scan_identification shifts between TDI and TDO.
// - The id word is revision, part, vendor and a fixed one in bit 0.
// - The 109-bit boundary register samples the io ring in capture-DR.
// - The boundary register then shifts once per tck in shift-DR.
// - TMS and TDI are taken on tck rises, TDO changes after falls.
// - Five tck rises with TMS high, or power-up, reach reset.
`timescale 1ns/1ps
`default_nettype none
module sjsr_top #(
   parameter logic [3:0] ID_REVISION = 4'h0, // arbitrary value
   parameter logic [15:0] ID_PART = 16'h5A5A, // arbitrary value
   parameter logic [10:0] ID_VENDOR = 11'h2A5 // arbitrary value
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic [sjsr_pkg::BND_W-1:0] io_ring_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   output logic [sjsr_pkg::IR_W-1:0] instruction_out,
   output logic [sjsr_pkg::BND_W-1:0] boundary_out
);

   // =====================================================
   // declarations
   localparam int NPIN = 3;
   localparam int PIN_TCK = 0;
   localparam int PIN_TMS = 1;
   localparam int PIN_TDI = 2;

   // pin capture, one column per test pin
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   logic tck_prev;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;

   // scan registers and the assembled id word
   logic [sjsr_pkg::IR_W-1:0] scan_instruction;
   logic [sjsr_pkg::IR_W-1:0] ir_shift;
   logic scan_bypass;
   logic [sjsr_pkg::ID_W-1:0] scan_identification;
   logic [sjsr_pkg::BND_W-1:0] scan_boundary;
   logic [sjsr_pkg::ID_W-1:0] id_word;

   // controller state and its decoded flags
   sjsr_pkg::sjsr_state_t state;
   sjsr_pkg::sjsr_dr_t dr_sel;
   logic st_reset;
   logic st_cap_dr;
   logic st_sh_dr;
   logic st_cap_ir;
   logic st_sh_ir;
   logic st_upd_ir;
   logic dr_bit;
   logic next_tdo;
   logic next_oe;
   // per-register step strobes
   logic tck_step;
   logic byp_sel;
   logic id_sel;
   logic bnd_sel;

   sjsr_tap_if tap ();

   // =====================================================
   // instruction decode, shared by capture, shift and output mux
   function automatic sjsr_pkg::sjsr_dr_t dr_of(
      input logic [sjsr_pkg::IR_W-1:0] op
   );
      sjsr_pkg::sjsr_dr_t r;
      r = sjsr_pkg::DR_BYPASS; // unknown codes fall to bypass
      if (op == sjsr_pkg::OP_IDCODE) begin
         r = sjsr_pkg::DR_ID;
      end else if (op == sjsr_pkg::OP_EXTEST ||
                   op == sjsr_pkg::OP_SAMPLE) begin
         r = sjsr_pkg::DR_BOUNDARY;
      end
      return r;
   endfunction

   // =====================================================
   // pin synchronisers, two stages each
   // tck, tms and tdi go through identical stages, so the sampled
   // mode and data bits line up with the detected tck edge
   assign pin_raw[PIN_TCK] = tck_in;
   assign pin_raw[PIN_TMS] = tms_in;
   assign pin_raw[PIN_TDI] = tdi_in;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         // first stage feeds only the second stage
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               pin_meta[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
            end else if (ce_in) begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   // test clock edge finder works on the settled stage only
   // its reset level matches the idle low tck, so no false edge
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tck_prev <= 1'b0;
      end else if (ce_in) begin
         tck_prev <= pin_sync[PIN_TCK];
      end
   end

   // tms and tdi share the sync delay with tck, so alignment holds
   assign tck_rise = pin_sync[PIN_TCK] & ~tck_prev;
   assign tck_fall = ~pin_sync[PIN_TCK] & tck_prev;
   assign tms_s = pin_sync[PIN_TMS];
   assign tdi_s = pin_sync[PIN_TDI];

   // =====================================================
   // controller
   // the fsm steps only on detected rises, never on the raw pin
   assign tap.tck_rise = tck_rise;
   assign tap.tms = tms_s;
   assign state = tap.state;

   sjsr_tap_fsm u_fsm (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .tap(tap)
   );

   // state decode
   // each flag is one compare; the DR flags are shared by several registers
   assign st_reset = (state == sjsr_pkg::ST_RESET);
   assign st_cap_dr = (state == sjsr_pkg::ST_CAP_DR);
   assign st_sh_dr = (state == sjsr_pkg::ST_SH_DR);
   assign st_cap_ir = (state == sjsr_pkg::ST_CAP_IR);
   assign st_sh_ir = (state == sjsr_pkg::ST_SH_IR);
   assign st_upd_ir = (state == sjsr_pkg::ST_UPD_IR);

   // only the active instruction picks the data path
   assign dr_sel = dr_of(scan_instruction);

   // one strobe per register keeps the clocked blocks short; the
   // selects also keep paths that are out of the chain untouched
   assign tck_step = ce_in & tck_rise;
   assign byp_sel = (dr_sel == sjsr_pkg::DR_BYPASS);
   assign id_sel = (dr_sel == sjsr_pkg::DR_ID);
   assign bnd_sel = (dr_sel == sjsr_pkg::DR_BOUNDARY);

   // =====================================================
   // identification word assembly
   // field values are parameters, the fixed bit is a constant
   assign id_word[sjsr_pkg::ID_REV_HI:sjsr_pkg::ID_REV_LO] = ID_REVISION;
   assign id_word[sjsr_pkg::ID_PART_HI:sjsr_pkg::ID_PART_LO] = ID_PART;
   assign id_word[sjsr_pkg::ID_VEND_HI:sjsr_pkg::ID_VEND_LO] = ID_VENDOR;
   assign id_word[sjsr_pkg::ID_FIX_BIT] = sjsr_pkg::ID_FIX_VAL;

   // =====================================================
   // instruction shifter and active instruction
   // the shifter and the held code are separate, so a scan in
   // progress never disturbs the instruction in force
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ir_shift <= sjsr_pkg::IR_CAPTURE_VAL;
      end else if (ce_in && tck_rise) begin
         if (st_cap_ir) begin
            ir_shift <= sjsr_pkg::IR_CAPTURE_VAL;
         end else if (st_sh_ir) begin
            // shifting only here keeps the held code untouched elsewhere
            ir_shift <= {tdi_s, ir_shift[sjsr_pkg::IR_W-1:1]};
         end
      end
   end

   // the new code is applied in update-IR, the step before idle or DR
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scan_instruction <= sjsr_pkg::OP_IDCODE;
      end else if (ce_in && tck_rise) begin
         if (st_reset) begin
            scan_instruction <= sjsr_pkg::OP_IDCODE;
         end else if (st_upd_ir) begin
            scan_instruction <= ir_shift;
         end
      end
   end

   // =====================================================
   // bypass stage
   // a captured zero lets a tester count the chips in the chain
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scan_bypass <= sjsr_pkg::BYPASS_CAPTURE_VAL;
      end else if (tck_step && byp_sel) begin
         if (st_cap_dr) begin
            scan_bypass <= sjsr_pkg::BYPASS_CAPTURE_VAL;
         end else if (st_sh_dr) begin
            scan_bypass <= tdi_s;
         end
      end
   end

   // =====================================================
   // identification register
   // only loads under the id opcode, other codes leave it alone
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scan_identification <= '0;
      end else if (tck_step && id_sel) begin
         if (st_cap_dr) begin
            scan_identification <= id_word;
         end else if (st_sh_dr) begin
            scan_identification <=
               {tdi_s, scan_identification[sjsr_pkg::ID_W-1:1]};
         end
      end
   end

   // =====================================================
   // boundary register
   // the ring is core-clock logic, so no synchroniser sits before it
   // capture takes the ring as it stands at the sampled tck rise
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scan_boundary <= '0;
      end else if (tck_step && bnd_sel) begin
         if (st_cap_dr) begin
            scan_boundary <= io_ring_in;
         end else if (st_sh_dr) begin
            scan_boundary <=
               {tdi_s, scan_boundary[sjsr_pkg::BND_W-1:1]};
         end
      end
   end

   // =====================================================
   // serial output select
   // the instruction path wins in shift-IR, else the selected DR
   assign dr_bit = (dr_sel == sjsr_pkg::DR_ID) ? scan_identification[0] :
                   (dr_sel == sjsr_pkg::DR_BOUNDARY) ? scan_boundary[0] :
                   scan_bypass;
   assign next_tdo = st_sh_ir ? ir_shift[0] : dr_bit;
   assign next_oe = st_sh_ir | st_sh_dr;

   // output moves only on tck falls, giving the far end half a period
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else if (ce_in && tck_fall) begin
         tdo_out <= next_tdo;
         tdo_oe_out <= next_oe;
      end
   end

   // =====================================================
   // visible copies of held state
   // one core cycle of lag buys outputs straight from flops
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         instruction_out <= sjsr_pkg::OP_IDCODE;
         boundary_out <= '0;
      end else if (ce_in) begin
         instruction_out <= scan_instruction;
         boundary_out <= scan_boundary;
      end
   end

   // =====================================================
   // limitations
   // tck pulses that start and end while the clock enable is low are lost
   // the boundary copy shows contents only, no pin is driven here
   // a tck faster than one sixth of the core clock is not supported

endmodule // sjsr_top
`default_nettype wire

//--- sjsr_pkg.sv
// Purpose: shared constants and types of the scan register block
// Assumes: test pins are sampled by the core clock
// Notes: opcode values belong to this block, not to a wider standard list
package sjsr_pkg;

   // =====================================================
   // register sizes
   localparam int IR_W = 3;
   localparam int ID_W = 32;
   localparam int BND_W = 109;
   localparam int SYNC_STAGES = 2;

   // =====================================================
   // identification word layout
   localparam int ID_REV_HI = 31;
   localparam int ID_REV_LO = 28;
   localparam int ID_PART_HI = 27;
   localparam int ID_PART_LO = 12;
   localparam int ID_VEND_HI = 11;
   localparam int ID_VEND_LO = 1;
   localparam int ID_FIX_BIT = 0;
   localparam logic ID_FIX_VAL = 1'b1;

   // =====================================================
   // instruction codes
   localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
   // fixed pattern put into the instruction shifter in capture-IR
   localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
   // value the bypass stage takes in capture-DR
   localparam logic BYPASS_CAPTURE_VAL = 1'b0;

   // =====================================================
   // test controller states, gray steps along the usual path
   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_IDLE = 4'h1,
      ST_SEL_DR = 4'h3,
      ST_CAP_DR = 4'h2,
      ST_SH_DR = 4'h6,
      ST_EX1_DR = 4'h7,
      ST_PA_DR = 4'h5,
      ST_EX2_DR = 4'h4,
      ST_UPD_DR = 4'hC,
      ST_SEL_IR = 4'hD,
      ST_CAP_IR = 4'hF,
      ST_SH_IR = 4'hE,
      ST_EX1_IR = 4'hA,
      ST_PA_IR = 4'hB,
      ST_EX2_IR = 4'h9,
      ST_UPD_IR = 4'h8
   } sjsr_state_t;

   // data register chosen by the active instruction
   typedef enum logic [1:0] {
      DR_BYPASS = 2'h0,
      DR_ID = 2'h1,
      DR_BOUNDARY = 2'h2
   } sjsr_dr_t;

endpackage

//--- sjsr_tap_if.sv
// Purpose: carrier between the scan core and its controller
// Assumes: one core clock for both ends
// Notes: edge strobe and sampled mode input travel together
`timescale 1ns/1ps
`default_nettype none
interface sjsr_tap_if;
   logic tck_rise;
   logic tms;
   sjsr_pkg::sjsr_state_t state;

   modport fsm (input tck_rise, input tms, output state);
   modport core (output tck_rise, output tms, input state);
endinterface
`default_nettype wire

//--- sjsr_tap_fsm.sv
// Purpose: sixteen-state test controller stepped on test clock rises
// Assumes: tck_rise is a one-cycle strobe already synchronised
// Notes: five rises with mode high reach reset from any state
`timescale 1ns/1ps
`default_nettype none
module sjsr_tap_fsm (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   sjsr_tap_if.fsm tap
);

   sjsr_pkg::sjsr_state_t state;
   sjsr_pkg::sjsr_state_t next_state;

   // =====================================================
   // next state from mode input
   always_comb begin
      next_state = state;
      unique case (state)
         sjsr_pkg::ST_RESET:
            next_state = tap.tms ? sjsr_pkg::ST_RESET : sjsr_pkg::ST_IDLE;
         sjsr_pkg::ST_IDLE:
            next_state = tap.tms ? sjsr_pkg::ST_SEL_DR : sjsr_pkg::ST_IDLE;
         sjsr_pkg::ST_SEL_DR:
            next_state = tap.tms ? sjsr_pkg::ST_SEL_IR : sjsr_pkg::ST_CAP_DR;
         sjsr_pkg::ST_CAP_DR:
            next_state = tap.tms ? sjsr_pkg::ST_EX1_DR : sjsr_pkg::ST_SH_DR;
         sjsr_pkg::ST_SH_DR:
            next_state = tap.tms ? sjsr_pkg::ST_EX1_DR : sjsr_pkg::ST_SH_DR;
         sjsr_pkg::ST_EX1_DR:
            next_state = tap.tms ? sjsr_pkg::ST_UPD_DR : sjsr_pkg::ST_PA_DR;
         sjsr_pkg::ST_PA_DR:
            next_state = tap.tms ? sjsr_pkg::ST_EX2_DR : sjsr_pkg::ST_PA_DR;
         sjsr_pkg::ST_EX2_DR:
            next_state = tap.tms ? sjsr_pkg::ST_UPD_DR : sjsr_pkg::ST_SH_DR;
         sjsr_pkg::ST_UPD_DR:
            next_state = tap.tms ? sjsr_pkg::ST_SEL_DR : sjsr_pkg::ST_IDLE;
         sjsr_pkg::ST_SEL_IR:
            next_state = tap.tms ? sjsr_pkg::ST_RESET : sjsr_pkg::ST_CAP_IR;
         sjsr_pkg::ST_CAP_IR:
            next_state = tap.tms ? sjsr_pkg::ST_EX1_IR : sjsr_pkg::ST_SH_IR;
         sjsr_pkg::ST_SH_IR:
            next_state = tap.tms ? sjsr_pkg::ST_EX1_IR : sjsr_pkg::ST_SH_IR;
         sjsr_pkg::ST_EX1_IR:
            next_state = tap.tms ? sjsr_pkg::ST_UPD_IR : sjsr_pkg::ST_PA_IR;
         sjsr_pkg::ST_PA_IR:
            next_state = tap.tms ? sjsr_pkg::ST_EX2_IR : sjsr_pkg::ST_PA_IR;
         sjsr_pkg::ST_EX2_IR:
            next_state = tap.tms ? sjsr_pkg::ST_UPD_IR : sjsr_pkg::ST_SH_IR;
         sjsr_pkg::ST_UPD_IR:
            next_state = tap.tms ? sjsr_pkg::ST_SEL_DR : sjsr_pkg::ST_IDLE;
      endcase
   end

   // =====================================================
   // state register, power-up lands in reset
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= sjsr_pkg::ST_RESET;
      end else if (ce_in && tap.tck_rise) begin
         state <= next_state;
      end
   end

   assign tap.state = state;

endmodule // sjsr_tap_fsm
`default_nettype wire

//--- sjsr_top_monitor.sv
// Purpose: port checker for the scan register block
// Assumes: test pins change just after core clock edges
// Notes: tck rises are found here with one flop of its own
`timescale 1ns/1ps
`default_nettype none
module sjsr_top_monitor (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic [sjsr_pkg::BND_W-1:0] io_ring_in,
   input wire logic tdo_out,
   input wire logic tdo_oe_out,
   input wire logic [sjsr_pkg::IR_W-1:0] instruction_out,
   input wire logic [sjsr_pkg::BND_W-1:0] boundary_out
);
   // =====================================================
   // helper: run of tck rises with tms high, saturating
   logic tck_q;
   logic [2:0] ones_cnt;
   wire tck_rise = tck_in & ~tck_q;
   wire [2:0] next_ones_cnt = !tms_in ? 3'h0 :
      (ones_cnt == 3'h5) ? 3'h5 : ones_cnt + 3'h1;

   // edge flop and run counter
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tck_q <= 1'b0;
         ones_cnt <= 3'h0;
      end else begin
         tck_q <= tck_in;
         if (tck_rise) ones_cnt <= next_ones_cnt;
      end
   end

   // =====================================================
   // assertions, one clock domain
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   AST_IR_RESET: assert property ($rose(rst_n_in) |->
      instruction_out == sjsr_pkg::OP_IDCODE)
      else $error("instruction not id after reset");
   // the id opcode loads on the rise after entry, hence the wide range
   AST_FIVE_ONES: assert property ($rose(ones_cnt == 3'h5) |->
      ##[0:30] instruction_out == sjsr_pkg::OP_IDCODE)
      else $error("five mode ones did not reset");
   AST_TDO_FALL: assert property ($changed(tdo_out) |->
      !tck_in && !$past(tck_in, 2))
      else $error("tdo moved outside tck low");
   AST_OE_FALL: assert property ($changed(tdo_oe_out) |->
      !tck_in && !$past(tck_in, 2))
      else $error("tdo enable moved outside tck low");
   AST_IR_UPDATE: assert property ($changed(instruction_out) |->
      tck_in && $past(tck_in, 3))
      else $error("instruction moved without tck rise");
   AST_BND_RISE: assert property ($changed(boundary_out) |->
      tck_in && $past(tck_in, 2))
      else $error("boundary moved without tck rise");
   AST_ONE_BIT: assert property ($changed(tdo_out) |=>
      $stable(tdo_out) [*8])
      else $error("tdo moved twice in one tck cycle");
   AST_ID_FIX: assert property (($rose(tdo_oe_out) &&
      instruction_out == sjsr_pkg::OP_IDCODE) |->
      tdo_out == sjsr_pkg::ID_FIX_VAL)
      else $error("first id bit not one");
endmodule // sjsr_top_monitor

bind sjsr_top sjsr_top_monitor u_sjsr_top_monitor (
   .core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in),
   .ce_in(ce_in),
   .tck_in(tck_in),
   .tms_in(tms_in),
   .tdi_in(tdi_in),
   .io_ring_in(io_ring_in),
   .tdo_out(tdo_out),
   .tdo_oe_out(tdo_oe_out),
   .instruction_out(instruction_out),
   .boundary_out(boundary_out)
);
`default_nettype wire

//--- sjsr_jtag_model.sv
// Purpose: test controller model on the far side of the test port
// Assumes: tck of 80 ns, stopped low between calls
// Notes: shifts lsb first, tdo taken just before each rise
`timescale 1ns/1ps
`default_nettype none
module sjsr_jtag_model (
   input wire logic core_clk_in,
   input wire logic tdo_in,
   input wire logic tdo_oe_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out
);
   logic last_q;

   // =====================================================
   // idle levels at time zero
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
      last_q = 1'b0;
   end

   // =====================================================
   // one tck period; released tdo reads as a moving value
   task automatic step(input logic m, input logic d, output logic q);
      tms_out = m;
      tdi_out = d;
      repeat (10) @(posedge core_clk_in);
      #1;
      q = tdo_oe_in ? tdo_in : ~last_q;
      last_q = q;
      tck_out = 1'b1;
      repeat (10) @(posedge core_clk_in);
      #1;
      tck_out = 1'b0;
   endtask

   // mode bits lsb first; 8'h1F,6 is five ones then idle
   task automatic walk(input logic [7:0] pat, input int n);
      logic q;
      for (int i = 0; i < n; i++) begin
         step(pat[i], 1'b0, q);
      end
   endtask

   // from idle through shift-IR and back to idle
   task automatic ir_scan(input logic [2:0] op, output logic [2:0] cap);
      walk(8'h03, 4);
      for (int i = 0; i < 3; i++) begin
         step(i == 2, op[i], cap[i]);
      end
      walk(8'h01, 2);
   endtask

   // from idle through shift-DR, n bits, back to idle
   task automatic dr_scan(input int n,
      input logic [sjsr_pkg::BND_W-1:0] din,
      output logic [sjsr_pkg::BND_W-1:0] dout);
      dout = '0;
      walk(8'h01, 3);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      walk(8'h01, 2);
   endtask
endmodule // sjsr_jtag_model
`default_nettype wire

//--- sjsr_top_tb_top.sv
// Purpose: self-checking bench of the scan register block
// Assumes: clock enable held high for the whole run
// Notes: all scans go through the controller model tasks
`timescale 1ns/1ps
`default_nettype none
module sjsr_top_tb_top;
   localparam logic [31:0] ID_WORD = {4'h6, 16'h9E31, 11'h1D3, 1'b1};
   localparam logic [108:0] IO_PAT = {1'b1, {9{12'hA5C}}};
   localparam logic [108:0] IN_PAT = {1'b0, {9{12'h3C9}}};
   logic core_clk_in = 1'b0;
   logic rst_n_in;
   logic [sjsr_pkg::BND_W-1:0] io_ring_in;
   logic [sjsr_pkg::BND_W-1:0] boundary_out;
   logic [sjsr_pkg::BND_W-1:0] d;
   logic [sjsr_pkg::IR_W-1:0] instruction_out;
   logic [sjsr_pkg::IR_W-1:0] q3;
   logic [2:0] ops [2] = '{sjsr_pkg::OP_EXTEST, sjsr_pkg::OP_SAMPLE};
   logic tck_in;
   logic tms_in;
   logic tdi_in;
   logic tdo_out;
   logic tdo_oe_out;
   int error_cnt = 0;
   int num_checks = 0;

   // =====================================================
   // clock and design under test
   always #2 core_clk_in = ~core_clk_in;

   // id field values are arbitrary
   sjsr_top #(
      .ID_REVISION(4'h6),
      .ID_PART(16'h9E31),
      .ID_VENDOR(11'h1D3)
   ) u_sjsr_top (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(1'b1),
      .tck_in(tck_in),
      .tms_in(tms_in),
      .tdi_in(tdi_in),
      .io_ring_in(io_ring_in),
      .tdo_out(tdo_out),
      .tdo_oe_out(tdo_oe_out),
      .instruction_out(instruction_out),
      .boundary_out(boundary_out)
   );

   sjsr_jtag_model u_sjsr_jtag_model (
      .core_clk_in(core_clk_in),
      .tdo_in(tdo_out),
      .tdo_oe_in(tdo_oe_out),
      .tck_out(tck_in),
      .tms_out(tms_in),
      .tdi_out(tdi_in)
   );

   // =====================================================
   // compare tasks and verdict
   task automatic chk(input logic [sjsr_pkg::BND_W-1:0] got,
      input logic [sjsr_pkg::BND_W-1:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %0t %s", $time, msg);
      end
   endtask

   task automatic chk_ir(input logic [2:0] got, input logic [2:0] exp,
      input string msg);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %0t %s", $time, msg);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // =====================================================
   // watchdog, nearly four times the expected run
   initial begin
      #100000;
      error_cnt++;
      $display("unexpected %0t watchdog expired", $time);
      print_verdict();
   end

   // =====================================================
   // main sequence
   initial begin
      rst_n_in = 1'b0;
      io_ring_in = '0;
      repeat (10) @(posedge core_clk_in);
      #1;
      rst_n_in = 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1;
      chk_ir(instruction_out, sjsr_pkg::OP_IDCODE, "ir reset");
      u_sjsr_jtag_model.walk(8'h1F, 6);
      repeat (5) @(posedge core_clk_in);
      #1;
      chk({108'h0, tdo_oe_out}, '0, "tdo driven in idle");
      u_sjsr_jtag_model.dr_scan(32, '0, d);
      chk(d, {77'h0, ID_WORD}, "id word");
      u_sjsr_jtag_model.ir_scan(sjsr_pkg::OP_BYPASS, q3);
      chk_ir(q3, sjsr_pkg::IR_CAPTURE_VAL, "ir capture");
      chk_ir(instruction_out, sjsr_pkg::OP_BYPASS, "ir load");
      // bypass: a zero first, then the input one bit late
      u_sjsr_jtag_model.dr_scan(8, 109'hB5, d);
      chk(d, 109'h6A, "bypass path");
      // both boundary instructions, io ring changed per pass
      foreach (ops[k]) begin
         io_ring_in = k ? IO_PAT : ~IO_PAT;
         u_sjsr_jtag_model.ir_scan(ops[k], q3);
         u_sjsr_jtag_model.dr_scan(sjsr_pkg::BND_W, IN_PAT, d);
         chk(d, io_ring_in, "boundary capture");
         chk(boundary_out, IN_PAT, "boundary shift");
      end
      // undefined code falls back to the bypass stage
      u_sjsr_jtag_model.ir_scan(3'h2, q3);
      u_sjsr_jtag_model.dr_scan(4, 109'hF, d);
      chk(d, 109'hE, "unknown code path");
      // four ones from shift-DR must not reset, the fifth must
      u_sjsr_jtag_model.walk(8'h79, 7);
      chk_ir(instruction_out, 3'h2, "four ones");
      u_sjsr_jtag_model.walk(8'h01, 2);
      chk_ir(instruction_out, sjsr_pkg::OP_IDCODE, "5 ones");
      print_verdict();
   end
endmodule // sjsr_top_tb_top
`default_nettype wire
